// File: trm_pkg.sv
// package of constants and types for the temperature rise and exchanger limit monitor
package trm_pkg;

  // ------------------------------------------------------------
  // bus and register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_RATE = 8'h04;
  localparam logic [7:0] ADDR_XSET = 8'h08;
  localparam logic [7:0] ADDR_DLY = 8'h0C;
  localparam logic [7:0] ADDR_RETRY = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;
  localparam logic [7:0] ADDR_CMD = 8'h18;

  // ctrl field positions
  localparam int CTRL_OUT_EN = 0;
  localparam int CTRL_XR_EN = 1;
  localparam int CTRL_XH_EN = 2;
  localparam int CTRL_RISE_RSP = 4;
  localparam int CTRL_XH_RSP = 6;
  localparam int CTRL_CONN = 8;
  // cmd bits
  localparam int CMD_CLR_LOCK = 0;
  localparam int CMD_CLR_RETRY = 1;

  // ------------------------------------------------------------
  // encodings
  // ------------------------------------------------------------
  typedef enum logic [1:0]
  {
    RSP_LOCKOUT = 2'b00,
    RSP_RECYCLE = 2'b01,
    RSP_RETRY = 2'b10
  } trm_rsp_t;

  localparam logic [2:0] CONN_10K_SINGLE = 3'h1;
  localparam logic [2:0] CONN_12K_SINGLE = 3'h2;
  // value meaning "none" for rate limit and setpoint
  localparam logic [15:0] LIMIT_NONE = 16'hFFFF;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam longint CLK_HZ = 10000000;
  localparam longint SAMPLE_MS = 1000;
  localparam longint PERSIST_S = 4;
  localparam longint SAMPLE_CYC = CLK_HZ * SAMPLE_MS / 1000;
  localparam logic [3:0] PERSIST_SAMPLES =
    4'(PERSIST_S * 1000 / SAMPLE_MS);
  localparam longint DLY_UNIT_CYC = CLK_HZ;

  typedef enum logic [1:0]
  {
    ST_RUN = 2'b00,
    ST_HOLD = 2'b01,
    ST_LOCK = 2'b10
  } trm_state_t;

endpackage

// File: trm_monitor.sv
// rise rate and exchanger high limit supervisor with apb registers
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
module trm_monitor
#(
  parameter longint SAMPLE_CYCLES = trm_pkg::SAMPLE_CYC,
  parameter longint DELAY_UNIT = trm_pkg::DLY_UNIT_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] outlet_temp_input,
  input wire logic [15:0] exchanger_temp_input,
  input wire logic [15:0] stack_temp_input,
  output logic lockout,
  output logic standby_hold,
  output logic recycle_pulse
);
  import trm_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed
  {
    logic [31:0] ctrl;
    logic [15:0] rate;
    logic [15:0] xset;
    logic [15:0] rise_dly;
    logic [15:0] xh_dly;
    logic [7:0] rise_n;
    logic [7:0] xh_n;
    logic [31:0] rdata;
    logic slverr;
    logic ready;
    logic [31:0] samp_cnt;
    logic [15:0] prev_out;
    logic [15:0] prev_x;
    logic primed;
    logic [3:0] pers_cnt;
    logic [7:0] rise_tries;
    logic [7:0] xh_tries;
    logic [31:0] unit_cnt;
    logic [15:0] hold_cnt;
    logic [3:0] cause;
    trm_state_t st;
    logic recycle;
    logic lock;
    logic hold;
  } trm_st_t;

  trm_st_t s_q;
  trm_st_t s_d;

  // ------------------------------------------------------------
  // combinational helpers
  // ------------------------------------------------------------
  logic acc;
  logic wr;
  logic tick;
  logic [15:0] d_out;
  logic [15:0] d_x;
  logic out_over;
  logic x_over;
  logic rate_over;
  logic conn_ok;
  logic conn_need;
  logic rise_evt;
  logic xh_evt;
  trm_rsp_t rise_rsp;
  trm_rsp_t xh_rsp;
  logic out_chk;
  logic x_chk;
  logic rise_lock;
  logic xh_lock;

  // ------------------------------------------------------------
  // combinational next state
  // ------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.recycle = 1'b0;
    acc = psel && penable;
    wr = acc && pwrite;
    rise_rsp = trm_rsp_t'(s_q.ctrl[CTRL_RISE_RSP +: 2]);
    xh_rsp = trm_rsp_t'(s_q.ctrl[CTRL_XH_RSP +: 2]);

    // ----------------------------------------------------------
    // apb read side
    // ----------------------------------------------------------
    // bus: zero wait, pready high in the access phase
    s_d.ready = psel && !penable;
    s_d.slverr = 1'b0;
    s_d.rdata = 32'h0;
    if (psel && !penable)
    begin
      unique case (paddr)
        ADDR_CTRL: s_d.rdata = s_q.ctrl;
        ADDR_RATE: s_d.rdata = {16'h0, s_q.rate};
        ADDR_XSET: s_d.rdata = {16'h0, s_q.xset};
        ADDR_DLY: s_d.rdata = {s_q.xh_dly, s_q.rise_dly};
        ADDR_RETRY: s_d.rdata = {16'h0, s_q.xh_n, s_q.rise_n};
        ADDR_STAT: s_d.rdata = {8'h0, s_q.xh_tries, s_q.rise_tries,
                                2'h0, s_q.cause, s_q.st};
        ADDR_CMD: s_d.rdata = 32'h0;
        default: s_d.slverr = 1'b1;
      endcase
    end

    // ----------------------------------------------------------
    // apb write side
    // ----------------------------------------------------------
    // registers only change at the committing access edge
    if (wr && s_q.ready)
    begin
      unique case (paddr)
        ADDR_CTRL: s_d.ctrl = {22'h0, pwdata[9:0]};
        ADDR_RATE: s_d.rate = pwdata[15:0];
        ADDR_XSET: s_d.xset = pwdata[15:0];
        ADDR_DLY:
        begin
          s_d.rise_dly = pwdata[15:0];
          s_d.xh_dly = pwdata[31:16];
        end
        ADDR_RETRY:
        begin
          s_d.rise_n = pwdata[7:0];
          s_d.xh_n = pwdata[15:8];
        end
        default:
        begin
          // status is read only; commands act further down
        end
      endcase
    end

    // ----------------------------------------------------------
    // rise rate
    // ----------------------------------------------------------
    // rate sampling on a fixed interval
    tick = (s_q.samp_cnt == 32'(SAMPLE_CYCLES - 1));
    s_d.samp_cnt = tick ? 32'h0 : s_q.samp_cnt + 32'h1;
    // one sample per second so the difference is degrees per second
    d_out = outlet_temp_input - s_q.prev_out;
    d_x = exchanger_temp_input - s_q.prev_x;
    // falling temperature wraps high; signed test rejects it
    out_over = !d_out[15] && (d_out > s_q.rate);
    x_over = !d_x[15] && (d_x > s_q.rate);
    // each input only counts while its own detection is enabled
    out_chk = s_q.ctrl[CTRL_OUT_EN] && out_over;
    x_chk = s_q.ctrl[CTRL_XR_EN] && x_over;
    rate_over = s_q.primed && (s_q.rate != LIMIT_NONE)
      && (out_chk || x_chk);
    rise_evt = 1'b0;
    if (tick)
    begin
      s_d.prev_out = outlet_temp_input;
      s_d.prev_x = exchanger_temp_input;
      // the first sample only primes the history
      s_d.primed = 1'b1;
      if (!rate_over)
        s_d.pers_cnt = 4'h0;
      else if (s_q.pers_cnt == PERSIST_SAMPLES - 4'h1)
      begin
        s_d.pers_cnt = 4'h0;
        rise_evt = 1'b1;
      end
      else
        s_d.pers_cnt = s_q.pers_cnt + 4'h1;
    end

    // ----------------------------------------------------------
    // exchanger limit and connector
    // ----------------------------------------------------------
    xh_evt = s_q.ctrl[CTRL_XH_EN] && (s_q.xset != LIMIT_NONE)
      && (exchanger_temp_input >= s_q.xset);

    // stack split into two single sensors needs a single-type connector
    conn_ok = (s_q.ctrl[CTRL_CONN +: 3] == CONN_10K_SINGLE)
      || (s_q.ctrl[CTRL_CONN +: 3] == CONN_12K_SINGLE);
    conn_need = s_q.ctrl[CTRL_XR_EN] || s_q.ctrl[CTRL_XH_EN];

    // ----------------------------------------------------------
    // delay timer
    // ----------------------------------------------------------
    // delay unit counter, seconds
    // free running; a new hold restarts it so the first second is whole
    s_d.unit_cnt = s_q.unit_cnt + 32'h1;
    if (s_q.unit_cnt == 32'(DELAY_UNIT - 1))
      s_d.unit_cnt = 32'h0;

    // ----------------------------------------------------------
    // response selection
    // ----------------------------------------------------------
    // a retry limit of zero behaves as a plain lockout
    xh_lock = (xh_rsp == RSP_LOCKOUT) || (xh_rsp == 2'b11)
      || (xh_rsp == RSP_RETRY && s_q.xh_tries >= s_q.xh_n);
    rise_lock = (rise_rsp == RSP_LOCKOUT) || (rise_rsp == 2'b11)
      || (rise_rsp == RSP_RETRY && s_q.rise_tries >= s_q.rise_n);

    // ----------------------------------------------------------
    // supervisor state machine
    // ----------------------------------------------------------
    unique case (s_q.st)
      ST_RUN:
      begin
        if (conn_need && !conn_ok)
        begin
          s_d.st = ST_LOCK;
          s_d.cause = 4'h1;
        end
        else if (xh_evt)
        begin
          // limit 0 acts as lockout; count reaching n locks out
          if (xh_lock)
          begin
            s_d.st = ST_LOCK;
            s_d.cause = 4'h3;
          end
          else
          begin
            if (xh_rsp == RSP_RETRY)
              s_d.xh_tries = s_q.xh_tries + 8'h1;
            s_d.st = ST_HOLD;
            s_d.recycle = 1'b1;
            s_d.hold_cnt = s_q.xh_dly;
            s_d.unit_cnt = 32'h0;
            s_d.cause = 4'h4;
          end
        end
        else if (rise_evt)
        begin
          if (rise_lock)
          begin
            s_d.st = ST_LOCK;
            s_d.cause = 4'h2;
          end
          else
          begin
            if (rise_rsp == RSP_RETRY)
              s_d.rise_tries = s_q.rise_tries + 8'h1;
            s_d.st = ST_HOLD;
            s_d.recycle = 1'b1;
            s_d.hold_cnt = s_q.rise_dly;
            s_d.unit_cnt = 32'h0;
            s_d.cause = 4'h5;
          end
        end
      end
      ST_HOLD:
      begin
        // a bad connector setting may not wait out the delay
        if (conn_need && !conn_ok)
        begin
          s_d.st = ST_LOCK;
          s_d.cause = 4'h1;
        end
        // standby until the delay runs out
        else if (s_q.hold_cnt == 16'h0)
          s_d.st = ST_RUN;
        else if (s_q.unit_cnt == 32'(DELAY_UNIT - 1))
          s_d.hold_cnt = s_q.hold_cnt - 16'h1;
        s_d.pers_cnt = 4'h0;
      end
      ST_LOCK:
      begin
        // nothing builds up while locked out
        s_d.pers_cnt = 4'h0;
      end
      default:
      begin
        s_d.st = ST_LOCK;
      end
    endcase

    // ----------------------------------------------------------
    // software commands
    // ----------------------------------------------------------
    // software commands; lockout is only left by the clear-lock command
    if (wr && s_q.ready && paddr == ADDR_CMD)
    begin
      if (pwdata[CMD_CLR_LOCK] && s_q.st == ST_LOCK)
      begin
        s_d.st = ST_RUN;
        s_d.cause = 4'h0;
      end
      if (pwdata[CMD_CLR_RETRY] && s_d.st != ST_HOLD)
      begin
        s_d.rise_tries = 8'h0;
        s_d.xh_tries = 8'h0;
      end
    end

    // ----------------------------------------------------------
    // pin flops
    // ----------------------------------------------------------
    // pins come from their own flops so no state decode reaches them
    s_d.lock = (s_d.st == ST_LOCK);
    s_d.hold = (s_d.st == ST_HOLD);
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '{st: ST_LOCK, lock: 1'b1, rate: LIMIT_NONE,
               xset: LIMIT_NONE, default: '0};
    else
      s_q <= s_d;
  end

  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.slverr;
  assign lockout = s_q.lock;
  assign standby_hold = s_q.hold;
  assign recycle_pulse = s_q.recycle;

endmodule // trm_monitor

// File: trm_monitor_chk.sv
// bus and response checker for the rise and exchanger monitor
`timescale 1ns/1ps
module trm_monitor_chk
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic lockout,
  input wire logic standby_hold,
  input wire logic recycle_pulse
);
  import trm_pkg::*;
  logic clr_q;
  // ------
  // checks
  // ------
  // only a committed clear command may end a lockout
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clr_q <= 1'b0;
    else
      clr_q <= psel && penable && pwrite && paddr == ADDR_CMD && pwdata[0];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  a_ready_setup: assert property (s_setup |=> pready) else $error("no ready");
  a_ready_one: assert property (pready |=> !pready) else $error("ready long");
  a_err_ready: assert property (pslverr |-> pready) else $error("lone err");
  a_map_ok: assert property (pready && paddr <= ADDR_CMD && paddr[1:0] == 2'h0
    |-> !pslverr) else $error("err mapped");
  a_pulse_one: assert property (recycle_pulse |=> !recycle_pulse)
    else $error("long pulse");
  a_pulse_run: assert property (recycle_pulse |-> !lockout)
    else $error("pulse locked");
  a_hold_free: assert property (standby_hold |-> !lockout)
    else $error("hold locked");
  a_lock_exit: assert property ($fell(lockout) |-> clr_q)
    else $error("lock left");
endmodule // trm_monitor_chk

bind trm_monitor trm_monitor_chk chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .lockout(lockout),
  .standby_hold(standby_hold), .recycle_pulse(recycle_pulse));

// File: trm_sensor_model.sv
// sensor front end model for the monitor
`timescale 1ns/1ps
module trm_sensor_model
(
  input wire logic pclk,
  input wire logic [15:0] step,
  input wire logic [15:0] xch_level,
  output logic [15:0] outlet_temp_input,
  output logic [15:0] exchanger_temp_input,
  output logic [15:0] stack_temp_input
);
  // -------
  // sensors
  // -------
  // ramp per clock, so rise per sample is step times the interval
  logic [15:0] out_q = 16'h0100;
  // stack toggles every clock; the monitor must never react to it
  logic [15:0] stk_q = 16'h0123;
  assign outlet_temp_input = out_q;
  assign exchanger_temp_input = xch_level;
  assign stack_temp_input = stk_q;
  always @(posedge pclk)
  begin
    out_q <= out_q + step;
    stk_q <= ~stk_q;
  end
endmodule // trm_sensor_model

// File: tb_temp_rise_exchanger_limit_monitor.sv
// self-checking bench for the rise and exchanger monitor
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb_temp_rise_exchanger_limit_monitor;
  import trm_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, lockout, standby_hold, recycle_pulse, lk, er;
  logic [15:0] step = 16'h0, xlvl = 16'h0, xs, ot, xt, st;
  logic [31:0] cv[3] = '{32'h2, 32'h304, 32'h202};
  logic ev[3] = '{1'b1, 1'b1, 1'b0};
  int err_count = 0, checked = 0, tries, cnt, wt;
  initial forever #50 pclk = ~pclk;
  trm_sensor_model sen_u (.pclk(pclk), .step(step), .xch_level(xlvl),
    .outlet_temp_input(ot), .exchanger_temp_input(xt),
    .stack_temp_input(st));
  trm_monitor #(.SAMPLE_CYCLES(10), .DELAY_UNIT(5)) dut_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .outlet_temp_input(ot), .exchanger_temp_input(xt),
    .stack_temp_input(st), .lockout(lockout), .standby_hold(standby_hold),
    .recycle_pulse(recycle_pulse));
  // -----
  // tasks
  // -----
  task automatic finish_test();
    $display("err_count=%0d checked=%0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do @(posedge pclk); while (pready !== 1'b1 && ++i < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge so a following setup never re-raises psel in this step
    @(posedge pclk);
    if (i >= 20)
    begin
      err_count++;
      finish_test();
    end
  endtask
  task automatic wait_ev(input int lim);
    cnt = 0;
    do @(posedge pclk);
    while (recycle_pulse !== 1'b1 && lockout !== 1'b1 && ++cnt < lim);
    lk = lockout;
  endtask
  // bench model: retry count decides lockout or a timed hold
  task automatic expect_ev(input int nl, input int dl);
    wait_ev(300);
    wt = cnt;
    `CHK(wt < 300, 1'b1)
    if (wt >= 300)
      finish_test();
    `CHK(lk, tries >= nl)
    if (!lk)
    begin
      tries++;
      cnt = 0;
      do @(posedge pclk); while (standby_hold === 1'b1 && ++cnt < 400);
      `CHK(cnt >= dl * 5 - 1 && cnt <= dl * 5 + 1, 1'b1)
      if (cnt >= 400)
        finish_test();
    end
  endtask
  // ---------
  // scenarios
  // ---------
  initial
  begin
    void'($urandom(78));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK(lockout, 1'b1)
    apb(0, 8'h1C, 0);
    `CHK(er, 1'b1)
    apb(1, ADDR_RATE, 32'h5);
    apb(1, ADDR_DLY, 32'h0001_0002);
    apb(1, ADDR_RETRY, 32'h0000_0201);
    apb(1, ADDR_CTRL, 32'h120);
    apb(1, ADDR_CMD, 32'h3);
    step <= 16'h0001;
    wait_ev(100);
    `CHK(cnt == 100 && !lk, 1'b1)
    apb(1, ADDR_CTRL, 32'h121);
    tries = 0;
    expect_ev(1, 2);
    `CHK(wt >= 30, 1'b1)
    expect_ev(1, 2);
    apb(0, ADDR_STAT, 0);
    `CHK(rd[5:0], 6'h0A)
    step <= 16'h0;
    apb(1, ADDR_XSET, 32'hFFFF);
    xlvl <= 16'hFFFF;
    apb(1, ADDR_CTRL, 32'h184);
    apb(1, ADDR_CMD, 32'h3);
    tries = 0;
    wait_ev(60);
    `CHK(cnt == 60 && !lk, 1'b1)
    xs = 16'($urandom_range(300, 100));
    xlvl <= xs - 16'h1;
    apb(1, ADDR_XSET, {16'h0, xs});
    wait_ev(60);
    `CHK(cnt == 60 && !lk, 1'b1)
    xlvl <= xs;
    repeat (3) expect_ev(2, 1);
    xlvl <= 16'h0;
    for (int i = 0; i < 3; i++)
    begin
      apb(1, ADDR_CTRL, cv[i]);
      apb(1, ADDR_CMD, 32'h1);
      repeat (3) @(posedge pclk);
      `CHK(lockout, ev[i])
    end
    finish_test();
  end
endmodule // tb_temp_rise_exchanger_limit_monitor
